// file: include/spm_pkg.sv
// package for the slot pin mode mux: types, register map, field positions
package spm_pkg;
  localparam int SPM_AW = 8;
  localparam logic [SPM_AW-1:0] SPM_CTRL_OFS = 8'h00;
  localparam logic [SPM_AW-1:0] SPM_STAT_OFS = 8'h04;
  localparam logic [SPM_AW-1:0] SPM_IRQ_STAT_OFS = 8'h08;
  localparam logic [SPM_AW-1:0] SPM_IRQ_CLR_OFS = 8'h0C;
  localparam logic [SPM_AW-1:0] SPM_IRQ_EN_OFS = 8'h10;
  // ctrl field positions
  localparam int SPM_CTRL_RESET_BIT = 0;
  localparam int SPM_CTRL_ATTN_BIT = 1;
  localparam int SPM_CTRL_AUXF_BIT = 2;
  localparam int SPM_CTRL_MAINF_BIT = 3;
  // interrupt event positions
  localparam int SPM_EV_MODE = 0;
  localparam int SPM_EV_CAP = 1;
  localparam int SPM_EV_PRES = 2;
  localparam int SPM_EV_FAULT = 3;
  localparam int SPM_EV_W = 4;
  localparam int SPM_CAP_W = 3;
  localparam logic [31:0] SPM_ZERO32 = 32'h0000_0000;
  localparam logic [SPM_EV_W-1:0] SPM_EV_ZERO = 4'h0;
  localparam logic [SPM_CAP_W-1:0] SPM_CAP_ZERO = 3'h0;
  localparam int SPM_LEVELS = 5;
  localparam int SPM_LEVEL_W_MAX = 8;
  // direct mode: capability bits 3/2/1 come from these decoded state bits
  localparam int SPM_CAP_BIT3_POS = 2;
  localparam int SPM_CAP_BIT2_POS = 1;
  localparam int SPM_CAP_BIT1_POS = 0;
  // presence sample register
  localparam int SPM_PRES_W = 2;
  localparam int SPM_PRES_BIT2_POS = 1;
  localparam int SPM_PRES_BIT1_POS = 0;
  // status word field positions
  localparam int SPM_STAT_DIRECT_BIT = 0;
  localparam int SPM_STAT_BUSEN_BIT = 1;
  localparam int SPM_STAT_AUXL_BIT = 2;
  localparam int SPM_STAT_MAINL_BIT = 3;
  localparam int SPM_STAT_PRES_POS = 4;
  localparam int SPM_STAT_CAP_POS = 6;

  typedef enum logic {SPM_MODE_SERIAL, SPM_MODE_DIRECT} spm_mode_t;

  // serial command stream: latch control strobe with the shifted enables
  typedef struct packed {
    logic shift_out_command;
    logic slot_a_latch_control;
    logic clk_en_val;
    logic bus_en_val;
  } spm_cmd_t;

  // pins shared between modes
  typedef struct packed {
    logic slot_a_reset_out;
    logic slot_a_clock_switch_enable;
    logic slot_a_bus_switch_enable;
  } spm_pins_t;
endpackage

// file: verilog/spm_cap_decode.sv
// capability level decoder: 5-level converter code to registered capability bits
`timescale 1ns/100ps
module spm_cap_decode #(
  parameter int LEVEL_W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // converter code and decoded state
  input wire logic [LEVEL_W-1:0] level_code,
  output logic [spm_pkg::SPM_CAP_W-1:0] cap_state
);
  import spm_pkg::*;

  if (LEVEL_W < $clog2(SPM_LEVELS)) begin : g_level_w_check
    $error("spm_cap_decode: LEVEL_W too small for five levels");
  end

  // codes above the top level saturate, so a noisy sense never leaves the five classes
  function automatic logic [SPM_CAP_W-1:0] classify(input logic [LEVEL_W-1:0] c);
    logic [SPM_CAP_W-1:0] r;
    r = SPM_CAP_ZERO;
    if (c >= LEVEL_W'(SPM_LEVELS - 1)) begin
      r = SPM_CAP_W'(SPM_LEVELS - 1);
    end else begin
      r = SPM_CAP_W'(c);
    end
    return r;
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_state <= SPM_CAP_ZERO;
    end else begin
      cap_state <= classify(level_code); // RULE1
    end
  end
endmodule // spm_cap_decode

// file: verilog/spm_pin_mux.sv
// slot A pin mode mux with apb status/control and interrupt
`timescale 1ns/100ps
// Operation
// RULE1 - the card capability sense is resolved into one of five levels.
// RULE2 - in serial mode the shared reset pin drives the card reset.
// RULE3 - in direct mode the shared reset pin shows capability bit 3.
// RULE4 - in direct mode the clock switch pin shows capability bit 2.
// RULE5 - in direct mode the bus switch pin shows capability bit 1.
// RULE6 - in serial mode presence bit 2 is sampled from its input.
// RULE7 - in serial mode presence bit 1 is sampled from its input.
// RULE8 - in direct mode the aux fault output shows an aux fault only while the digital supply is off.
// RULE9 - in direct mode the slot fault output asserts on aux or main fault while power good is high.
// RULE10 - in serial mode the clock switch enable connects the bus clock to the slot.
// RULE11 - the clock switch enable resets low and changes only on shift out with latch control.
// RULE12 - the bus switch enable resets low and changes only on shift out with latch control.
// RULE13 - the mode is latched at the rising edge of power good and selects every pin function.
// RULE14 - while power good is low the attention indicator shows the aux fault latch.
// RULE15 - the latched mode holds until the next rising edge of power good.
module spm_pin_mux #(
  parameter int LEVEL_W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spm_pkg::SPM_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system
  input wire logic system_power_good,
  input wire logic mode_select,
  input wire logic digital_supply,
  // slot inputs
  input wire logic [LEVEL_W-1:0] slot_a_card_capability_sense,
  input wire logic slot_a_presence_bit2,
  input wire logic slot_a_presence_bit1,
  input wire logic slot_a_aux_fault_event,
  input wire logic slot_a_main_fault_event,
  input wire logic slot_a_aux_fault_clear,
  // serial command stream
  input wire spm_pkg::spm_cmd_t serial_cmd,
  // slot pins
  output spm_pkg::spm_pins_t slot_pins,
  output logic slot_a_aux_fault_out,
  output logic slot_a_power_fault_out,
  output logic slot_a_attention_indicator,
  // interrupt
  output logic irq
);
  import spm_pkg::*;

  if (LEVEL_W < $clog2(SPM_LEVELS) || LEVEL_W > SPM_LEVEL_W_MAX) begin : g_level_w_check
    $error("spm_pin_mux: LEVEL_W out of range");
  end

  spm_mode_t mode_r;
  logic system_power_good_d_r;
  logic clk_en_r, bus_en_r;
  logic reset_pin_r, clk_pin_r, bus_pin_r;
  logic [SPM_PRES_W-1:0] presence_r;
  logic aux_latch_r, main_latch_r;
  logic [31:0] ctrl_r;
  logic [SPM_EV_W-1:0] irq_stat_r, irq_en_r;
  logic [SPM_CAP_W-1:0] cap_state, cap_d_r;
  logic system_power_good_rise, is_direct, wr;
  logic [SPM_EV_W-1:0] events, clr;

  // one address compare serves every register write strobe
  function automatic logic wr_hit(input logic strobe, input logic [SPM_AW-1:0] a, input logic [SPM_AW-1:0] ofs);
    return strobe && (a == ofs);
  endfunction

  // interrupt registers read back zero-extended
  function automatic logic [31:0] ev_word(input logic [SPM_EV_W-1:0] v);
    logic [31:0] w;
    w = SPM_ZERO32;
    w[SPM_EV_W-1:0] = v;
    return w;
  endfunction

  // status word: capability, presence, fault latches, bus enable and mode
  function automatic logic [31:0] stat_word(input logic [SPM_CAP_W-1:0] cap, input logic [SPM_PRES_W-1:0] pres,
    input logic main_f, input logic aux_f, input logic bus_en, input logic direct);
    logic [31:0] w;
    w = SPM_ZERO32;
    w[SPM_STAT_CAP_POS +: SPM_CAP_W] = cap;
    w[SPM_STAT_PRES_POS +: SPM_PRES_W] = pres;
    w[SPM_STAT_MAINL_BIT] = main_f;
    w[SPM_STAT_AUXL_BIT] = aux_f;
    w[SPM_STAT_BUSEN_BIT] = bus_en;
    w[SPM_STAT_DIRECT_BIT] = direct;
    return w;
  endfunction

  spm_cap_decode #(.LEVEL_W(LEVEL_W)) u_cap (
    .clk(clk),
    .rst(rst),
    .level_code(slot_a_card_capability_sense),
    .cap_state(cap_state)
  );

  assign system_power_good_rise = system_power_good & ~system_power_good_d_r;
  assign is_direct = (mode_r == SPM_MODE_DIRECT);
  // zero-wait apb: write at access phase
  assign wr = psel & penable & pwrite;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      system_power_good_d_r <= 1'b0;
    end else begin
      system_power_good_d_r <= system_power_good;
    end
  end

  // mode sampled from the strap only on the power good edge; never tracks it afterwards
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= SPM_MODE_SERIAL;
    end else if (system_power_good_rise) begin
      mode_r <= mode_select ? SPM_MODE_DIRECT : SPM_MODE_SERIAL; // RULE13 RULE15
    end
  end

  // switch enables move only on a latched shift out command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_en_r <= 1'b0;
      bus_en_r <= 1'b0;
    end else if (serial_cmd.shift_out_command && serial_cmd.slot_a_latch_control) begin
      clk_en_r <= serial_cmd.clk_en_val; // RULE11 RULE10
      bus_en_r <= serial_cmd.bus_en_val; // RULE12
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presence_r <= 2'h0;
    end else if (!is_direct) begin
      presence_r[SPM_PRES_BIT2_POS] <= slot_a_presence_bit2; // RULE6
      presence_r[SPM_PRES_BIT1_POS] <= slot_a_presence_bit1; // RULE7
    end
  end

  // fault latches: set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux_latch_r <= 1'b0;
      main_latch_r <= 1'b0;
    end else begin
      aux_latch_r <= slot_a_aux_fault_event | (aux_latch_r & ~slot_a_aux_fault_clear);
      main_latch_r <= slot_a_main_fault_event | (main_latch_r & ~slot_a_aux_fault_clear);
    end
  end

  // pin functions: each pin flop picks its source from the latched mode
  assign slot_pins = {reset_pin_r, clk_pin_r, bus_pin_r};

  // capability class as three bits: bit3 is the msb of the decoded state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_pin_r <= 1'b0;
    end else if (is_direct) begin
      reset_pin_r <= cap_state[SPM_CAP_BIT3_POS]; // RULE3
    end else begin
      reset_pin_r <= ctrl_r[SPM_CTRL_RESET_BIT]; // RULE2
    end
  end

  // switch enables are kept in direct mode but only reach the pins in serial mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_pin_r <= 1'b0;
    end else if (is_direct) begin
      clk_pin_r <= cap_state[SPM_CAP_BIT2_POS]; // RULE4
    end else begin
      clk_pin_r <= clk_en_r; // RULE10
    end
  end

  // bus switch pin shares its flop with the lowest capability bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_pin_r <= 1'b0;
    end else if (is_direct) begin
      bus_pin_r <= cap_state[SPM_CAP_BIT1_POS]; // RULE5
    end else begin
      bus_pin_r <= bus_en_r; // RULE12
    end
  end

  // aux fault pin only has meaning in direct mode with the digital supply off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_a_aux_fault_out <= 1'b0;
    end else begin
      slot_a_aux_fault_out <= is_direct & aux_latch_r & ~digital_supply; // RULE8
    end
  end

  // slot fault stays quiet in serial mode, where the serial stream reports faults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_a_power_fault_out <= 1'b0;
    end else begin
      slot_a_power_fault_out <= is_direct & (aux_latch_r | main_latch_r) & system_power_good; // RULE9
    end
  end

  // attention falls back to the aux latch while software cannot drive it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_a_attention_indicator <= 1'b0;
    end else if (!system_power_good) begin
      slot_a_attention_indicator <= aux_latch_r; // RULE14
    end else if (is_direct && !digital_supply) begin
      slot_a_attention_indicator <= aux_latch_r; // RULE8
    end else begin
      slot_a_attention_indicator <= ctrl_r[SPM_CTRL_ATTN_BIT];
    end
  end

  // control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= SPM_ZERO32;
    end else if (wr_hit(wr, paddr, SPM_CTRL_OFS)) begin
      ctrl_r <= SPM_ZERO32;
      ctrl_r[SPM_CTRL_RESET_BIT] <= pwdata[SPM_CTRL_RESET_BIT];
      ctrl_r[SPM_CTRL_ATTN_BIT] <= pwdata[SPM_CTRL_ATTN_BIT];
    end
  end

  // interrupt events
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_d_r <= SPM_CAP_ZERO;
    end else begin
      cap_d_r <= cap_state;
    end
  end

  always_comb begin
    events = SPM_EV_ZERO;
    events[SPM_EV_MODE] = system_power_good_rise;
    events[SPM_EV_CAP] = (cap_d_r != cap_state);
    events[SPM_EV_PRES] = !is_direct &&
      (presence_r != {slot_a_presence_bit2, slot_a_presence_bit1});
    events[SPM_EV_FAULT] = slot_a_aux_fault_event | slot_a_main_fault_event;
    clr = wr_hit(wr, paddr, SPM_IRQ_CLR_OFS) ? pwdata[SPM_EV_W-1:0] : SPM_EV_ZERO;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= SPM_EV_ZERO;
    end else begin
      irq_stat_r <= events | (irq_stat_r & ~clr);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en_r <= SPM_EV_ZERO;
    end else if (wr_hit(wr, paddr, SPM_IRQ_EN_OFS)) begin
      irq_en_r <= pwdata[SPM_EV_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_en_r);
    end
  end

  // apb read path; ready in the first access cycle, unmapped addresses answer slverr
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= SPM_ZERO32;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= SPM_ZERO32;
      if (psel && !penable) begin
        case (paddr)
          SPM_CTRL_OFS: prdata <= pwrite ? SPM_ZERO32 : ctrl_r;
          SPM_STAT_OFS: prdata <= pwrite ? SPM_ZERO32 : stat_word(cap_state, presence_r,
            main_latch_r, aux_latch_r, bus_en_r, is_direct);
          SPM_IRQ_STAT_OFS: prdata <= pwrite ? SPM_ZERO32 : ev_word(irq_stat_r);
          SPM_IRQ_CLR_OFS: prdata <= SPM_ZERO32;
          SPM_IRQ_EN_OFS: prdata <= pwrite ? SPM_ZERO32 : ev_word(irq_en_r);
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // spm_pin_mux

// file: verification/spm_slot_model.sv
// behavioural model of the slot A card and its presence and capability lines
`timescale 1ns/100ps
module spm_slot_model #(
  parameter int LEVEL_W = 3
) (
  // card state chosen by the bench
  input wire logic clk,
  input wire logic card_in,
  input wire logic [LEVEL_W-1:0] card_level,
  input wire logic [1:0] card_prsnt,
  // slot lines
  output logic [LEVEL_W-1:0] sense,
  output logic prsnt2,
  output logic prsnt1
);
  // an empty slot leaves the presence lines on their pull-ups and shows the lowest level
  always_ff @(posedge clk) begin
    sense <= card_in ? card_level : {LEVEL_W{1'h0}};
    {prsnt2, prsnt1} <= card_in ? card_prsnt : 2'h3;
  end
endmodule // spm_slot_model

// file: verification/spm_pin_mux_chk.sv
// concurrent checks on the slot pin mode mux ports
`timescale 1ns/100ps
module spm_pin_mux_chk #(
  parameter int LEVEL_W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spm_pkg::SPM_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // system and slot inputs
  input wire logic system_power_good,
  input wire logic mode_select,
  input wire logic digital_supply,
  input wire logic [LEVEL_W-1:0] slot_a_card_capability_sense,
  input wire logic slot_a_presence_bit2,
  input wire logic slot_a_presence_bit1,
  input wire logic slot_a_aux_fault_event,
  input wire logic slot_a_main_fault_event,
  input wire logic slot_a_aux_fault_clear,
  input wire spm_pkg::spm_cmd_t serial_cmd,
  // pins
  input wire spm_pkg::spm_pins_t slot_pins,
  input wire logic slot_a_aux_fault_out,
  input wire logic slot_a_power_fault_out,
  input wire logic slot_a_attention_indicator
);
  import spm_pkg::*;
  logic pg_q, md, al, ml, ctl;
  logic [1:0] en;
  logic [2:0] q;
  wire rise = system_power_good & ~pg_q;
  wire stb = serial_cmd.shift_out_command & serial_cmd.slot_a_latch_control;
  wire acc = psel & penable & pready;
  wire [1:0] pr = {slot_a_presence_bit2, slot_a_presence_bit1};
  wire [2:0] cap = (slot_a_card_capability_sense > 4) ? 3'h4 : slot_a_card_capability_sense[2:0];
  wire aq = !slot_a_aux_fault_event && !slot_a_aux_fault_clear;
  // shadow of mode, latches and enables; q holds off checks while the mode settles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {pg_q, md, al, ml, ctl, en, q} <= 10'h000;
    end else begin
      pg_q <= system_power_good;
      md <= rise ? mode_select : md;
      q <= rise ? 3'h0 : (q == 3'h7 ? q : q + 3'h1);
      al <= slot_a_aux_fault_event | (al & ~slot_a_aux_fault_clear);
      ml <= slot_a_main_fault_event | (ml & ~slot_a_aux_fault_clear);
      ctl <= (acc && pwrite && paddr == SPM_CTRL_OFS) ? pwdata[0] : ctl;
      en <= stb ? {serial_cmd.clk_en_val, serial_cmd.bus_en_val} : en;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_cap; (md && q == 7 && $stable(slot_a_card_capability_sense))[*4] |-> slot_pins == cap; endproperty
  a_cap: assert property (p_cap) else $error("capability pins wrong");
  property p_sw; (!md && q == 7 && !stb)[*3] |-> slot_pins[1:0] == en; endproperty
  a_sw: assert property (p_sw) else $error("switch enables wrong");
  property p_rst; (!md && q == 7 && !(acc && pwrite))[*3] |-> slot_pins.slot_a_reset_out == ctl; endproperty
  a_rst: assert property (p_rst) else $error("slot reset wrong");
  property p_aux; (md && q == 7 && aq && $stable(digital_supply))[*3] |->
    slot_a_aux_fault_out == (al & ~digital_supply); endproperty
  a_aux: assert property (p_aux) else $error("aux fault out wrong");
  property p_flt; (md && q == 7 && aq && !slot_a_main_fault_event && $stable(system_power_good))[*3] |->
    slot_a_power_fault_out == ((al | ml) & system_power_good); endproperty
  a_flt: assert property (p_flt) else $error("slot fault out wrong");
  property p_ser; !md && q == 7 |-> !slot_a_aux_fault_out && !slot_a_power_fault_out; endproperty
  a_ser: assert property (p_ser) else $error("fault pins active in serial mode");
  property p_att; (!system_power_good && aq)[*3] |-> slot_a_attention_indicator == al; endproperty
  a_att: assert property (p_att) else $error("attention wrong with power good low");
  property p_prs; acc && !pwrite && paddr == SPM_STAT_OFS && !md && q == 7 && $past(pr, 3) == pr
    && $past(pr, 2) == pr && $past(pr) == pr |-> prdata[5:4] == pr; endproperty
  a_prs: assert property (p_prs) else $error("presence bits wrong");
  c_dir: cover property (md && q == 7);
  c_stb: cover property (!md && stb);
  c_aux: cover property (slot_a_aux_fault_out);
endmodule // spm_pin_mux_chk

// file: verification/testbench.sv
// self-checking bench for the slot pin mode mux
`timescale 1ns/100ps
module testbench;
  import spm_pkg::*;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, err, irq;
  logic pg = 1'h0, msel = 1'h0, sup = 1'h1, aev = 1'h0, mev = 1'h0, aclr = 1'h0, card_in = 1'h0;
  logic p2, p1, auxo, pfo, attn;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] lvl = 3'h0, sense;
  logic [1:0] prs = 2'h1;
  spm_cmd_t cmd = 4'h0;
  spm_pins_t pins;
  int num_errors = 0, checked = 0, cyc = 0;
  spm_pin_mux #(.LEVEL_W(3)) i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .system_power_good(pg), .mode_select(msel), .digital_supply(sup), .slot_a_card_capability_sense(sense),
    .slot_a_presence_bit2(p2), .slot_a_presence_bit1(p1), .slot_a_aux_fault_event(aev), .slot_a_main_fault_event(mev),
    .slot_a_aux_fault_clear(aclr), .serial_cmd(cmd), .slot_pins(pins), .slot_a_aux_fault_out(auxo),
    .slot_a_power_fault_out(pfo), .slot_a_attention_indicator(attn), .irq);
  spm_slot_model #(.LEVEL_W(3)) i_slot (.clk, .card_in, .card_level(lvl), .card_prsnt(prs), .sense, .prsnt2(p2),
    .prsnt1(p1));
  always #4 clk = ~clk;
  // the run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    tick(1);
    penable <= 1'h1;
    tick(1);
    while (pready !== 1'h1) tick(1);
    rd = prdata;
    err = pslverr;
    // an idle edge after each transfer, so a following call never drives psel twice in one step
    {psel, penable} <= 2'h0;
    tick(1);
  endtask
  task automatic fire(input logic a, input logic m);
    {aev, mev} <= {a, m};
    tick(1);
    {aev, mev} <= 2'h0;
    tick(4);
  endtask
  function automatic logic [2:0] capx(input logic [2:0] l);
    return (l > 3'h4) ? 3'h4 : l;
  endfunction
  initial begin
    spm_cmd_t sc;
    logic [1:0] en;
    void'($urandom(68));
    en = 2'h0;
    tick(2);
    {rst, card_in} <= 2'h1;
    tick(2);
    pg <= 1'h1;
    tick(4);
    for (int k = 0; k < 12; k++) begin
      sc = 4'($urandom);
      // corner cases first: a latched strobe setting both enables, then one clearing them
      if (k < 2) sc = (k == 0) ? 4'hF : 4'hC;
      {cmd, prs} <= {sc, sc[3:2]};
      tick(1);
      cmd <= 4'h0;
      if (sc.shift_out_command && sc.slot_a_latch_control) en = sc[1:0];
      tick(3);
      chk(pins[1:0], en);
      apb(1'h1, SPM_CTRL_OFS, {30'h0, sc.bus_en_val, sc.clk_en_val});
      apb(1'h0, SPM_STAT_OFS, 32'h0);
      chk(rd[5:4], sc[3:2]);
      tick(2);
      chk(pins.slot_a_reset_out, sc.clk_en_val);
      chk(attn, sc.bus_en_val);
    end
    fire(1'h1, 1'h0);
    chk({auxo, pfo}, 2'h0);
    $display("serial mode test done");
    {pg, msel} <= 2'h1;
    tick(2);
    pg <= 1'h1;
    tick(4);
    for (int i = 7; i >= 0; i--) begin
      lvl <= 3'(i);
      tick(5);
      chk(pins, capx(3'(i)));
    end
    {msel, lvl} <= 4'h3;
    tick(5);
    chk(pins, 3'h3);
    sup <= 1'h0;
    fire(1'h1, 1'h0);
    chk({auxo, pfo, attn}, 3'h7);
    sup <= 1'h1;
    tick(4);
    chk({auxo, pfo}, 2'h1);
    aclr <= 1'h1;
    tick(2);
    aclr <= 1'h0;
    fire(1'h0, 1'h1);
    chk({auxo, pfo}, 2'h1);
    pg <= 1'h0;
    tick(4);
    chk({pfo, attn}, 2'h0);
    fire(1'h1, 1'h0);
    chk(attn, 1'h1);
    $display("direct mode test done");
    apb(1'h0, SPM_IRQ_STAT_OFS, 32'h0);
    chk(rd[3:0], 4'hF);
    chk(irq, 1'h0);
    apb(1'h1, SPM_IRQ_EN_OFS, 32'h8);
    tick(2);
    chk(irq, 1'h1);
    apb(1'h1, SPM_IRQ_CLR_OFS, 32'hF);
    tick(2);
    chk(irq, 1'h0);
    fire(1'h0, 1'h1);
    chk(irq, 1'h1);
    apb(1'h0, 8'h40, 32'h0);
    chk(err, 1'h1);
    $display("register test done");
    wrap_up();
  end
endmodule // testbench
bind spm_pin_mux spm_pin_mux_chk #(.LEVEL_W(LEVEL_W)) i_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .system_power_good, .mode_select, .digital_supply, .slot_a_card_capability_sense,
  .slot_a_presence_bit2, .slot_a_presence_bit1, .slot_a_aux_fault_event, .slot_a_main_fault_event,
  .slot_a_aux_fault_clear, .serial_cmd, .slot_pins, .slot_a_aux_fault_out, .slot_a_power_fault_out,
  .slot_a_attention_indicator);
